//--- hw/status_output_selector.v
// Status output selector: routes drive status sources onto five switch
// terminals, with an AHB-Lite register slave for the selector codes.
// Assumes all status inputs are synchronous to CLOCK.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`include "selector_defs.vh"

module status_output_selector (
  // Clock and reset
  input  wire                  CLOCK,
  input  wire                  RST_N,
  // AHB-Lite slave
  input  wire                  HSEL,
  input  wire [31:0]           HADDR,
  input  wire [1:0]            HTRANS,
  input  wire                  HWRITE,
  input  wire [2:0]            HSIZE,
  input  wire [31:0]           HWDATA,
  input  wire                  HREADY,
  output reg                   HREADYOUT,
  output reg                   HRESP,
  output reg  [31:0]           HRDATA,
  // Drive state sources
  input  wire                  DRIVE_RUNNING,
  input  wire                  FAULT_STOP,
  input  wire                  BRAKE_RELEASE_OK,
  input  wire                  RUN_REQUEST,
  input  wire                  DRIVE_READY,
  input  wire                  DIRECTION_CMD,
  // Speed step command bits
  input  wire                  SPEED_STEP_BIT0,
  input  wire                  SPEED_STEP_BIT1,
  input  wire                  SPEED_STEP_BIT2,
  input  wire                  SPEED_STEP_BIT3,
  // Fault warnings
  input  wire                  ANY_FAULT,
  input  wire                  OVERHEAT_WARNING,
  input  wire                  OVERLOAD_WARNING,
  input  wire                  OVERSPEED_WARNING,
  // Motor selection
  input  wire                  MOTOR1_SELECTED,
  input  wire                  MOTOR2_SELECTED,
  input  wire                  MOTOR3_SELECTED,
  input  wire                  MOTOR4_SELECTED,
  // Speed and supply
  input  wire [`FREQ_W-1:0]    OUTPUT_FREQ,
  input  wire                  PRECHARGE_STATUS,
  input  wire                  ACTIVE_FRONT_END,
  // Fieldbus, local and free block functions
  input  wire [4:0]            FIELDBUS_FUNC,
  input  wire [3:0]            LOCAL_FUNC,
  input  wire [3:0]            FREE_BLOCK_RESULT,
  // Free block settings for the block logic
  output reg  [`LOGIC_W-1:0]   CUSTOM_LOGIC_SETTING_1,
  output reg  [`LOGIC_W-1:0]   CUSTOM_LOGIC_SETTING_2,
  output reg  [`LOGIC_W-1:0]   CUSTOM_LOGIC_SETTING_3,
  output reg  [`LOGIC_W-1:0]   CUSTOM_LOGIC_SETTING_4,
  // Switch terminals
  output reg                   SWITCH_OUT_1,
  output reg                   SWITCH_OUT_2,
  output reg                   SWITCH_OUT_3,
  output reg                   SWITCH_OUT_4,
  output reg                   SWITCH_OUT_5
);

  // Selector code registers
  reg  [`SEL_W-1:0]    sel1_r;
  reg  [`SEL_W-1:0]    sel2_r;
  reg  [`SEL_W-1:0]    sel3_r;
  reg  [`SEL_W-1:0]    sel4_r;
  reg  [`SEL_W-1:0]    sel5_r;
  reg  [`SEL_W-1:0]    sel1_nxt;
  reg  [`SEL_W-1:0]    sel2_nxt;
  reg  [`SEL_W-1:0]    sel3_nxt;
  reg  [`SEL_W-1:0]    sel4_nxt;
  reg  [`SEL_W-1:0]    sel5_nxt;
  // Free block settings and speed limit
  reg  [`LOGIC_W-1:0]  logic1_nxt;
  reg  [`LOGIC_W-1:0]  logic2_nxt;
  reg  [`LOGIC_W-1:0]  logic3_nxt;
  reg  [`LOGIC_W-1:0]  logic4_nxt;
  reg  [`FREQ_W-1:0]   speed_lim_r;
  reg  [`FREQ_W-1:0]   speed_lim_nxt;
  // Sticky flag for refused writes
  reg                  reject_r;
  reg                  reject_nxt;
  // Bus data phase state
  reg                  wr_pend_r;
  reg  [7:0]           wr_addr_r;
  reg  [31:0]          rdata_nxt;
  // Source vector and picks
  reg  [`NUM_SRC-1:0]  src;
  wire [4:0]           pick;
  wire [`SEL_W*5-1:0]  sel_bus;
  wire [4:0]           out_now;
  wire                 addr_ok;
  wire                 wr_sel_ok;
  wire                 wr_logic_ok;
  wire                 addr_is_sel;
  wire                 addr_is_logic;

  // Address phase qualifier: active transfer with the bus ready
  assign addr_ok = HSEL & HREADY & HTRANS[1];

  // Current terminal levels for status readback
  assign out_now = {SWITCH_OUT_5, SWITCH_OUT_4, SWITCH_OUT_3,
                    SWITCH_OUT_2, SWITCH_OUT_1};

  // Which register group the pending write targets; exact word offsets only,
  // so a stray write between registers never raises the refusal flag
  assign addr_is_sel   = (wr_addr_r == `OFS_SEL1) ||
                         (wr_addr_r == `OFS_SEL2) ||
                         (wr_addr_r == `OFS_SEL3) ||
                         (wr_addr_r == `OFS_SEL4) ||
                         (wr_addr_r == `OFS_SEL5);
  assign addr_is_logic = (wr_addr_r == `OFS_LOGIC1) ||
                         (wr_addr_r == `OFS_LOGIC2) ||
                         (wr_addr_r == `OFS_LOGIC3) ||
                         (wr_addr_r == `OFS_LOGIC4);

  // Range checks on write data; out of range codes are refused
  assign wr_sel_ok   = (HWDATA[31:`SEL_W] == 25'h000_0000) &&
                       (HWDATA[`SEL_W-1:0] <= `SEL_MAX);
  assign wr_logic_ok = (HWDATA[31:`LOGIC_W] == 23'h00_0000) &&
                       (HWDATA[`LOGIC_W-1:0] <= `LOGIC_MAX);

  // Register write decode in the data phase. The address was captured at the
  // previous edge and HWDATA stands now, so the register takes its new value
  // at the edge that closes the data phase. Bus size is not checked: every
  // register is one whole word and narrower transfers are not expected.
  always @* begin
    sel1_nxt      = sel1_r;
    sel2_nxt      = sel2_r;
    sel3_nxt      = sel3_r;
    sel4_nxt      = sel4_r;
    sel5_nxt      = sel5_r;
    logic1_nxt    = CUSTOM_LOGIC_SETTING_1;
    logic2_nxt    = CUSTOM_LOGIC_SETTING_2;
    logic3_nxt    = CUSTOM_LOGIC_SETTING_3;
    logic4_nxt    = CUSTOM_LOGIC_SETTING_4;
    speed_lim_nxt = speed_lim_r;
    reject_nxt    = reject_r;
    if (wr_pend_r) begin
      case (wr_addr_r)
        `OFS_SEL1: begin
          if (wr_sel_ok) sel1_nxt = HWDATA[`SEL_W-1:0];
        end
        `OFS_SEL2: begin
          if (wr_sel_ok) sel2_nxt = HWDATA[`SEL_W-1:0];
        end
        `OFS_SEL3: begin
          if (wr_sel_ok) sel3_nxt = HWDATA[`SEL_W-1:0];
        end
        `OFS_SEL4: begin
          if (wr_sel_ok) sel4_nxt = HWDATA[`SEL_W-1:0];
        end
        `OFS_SEL5: begin
          if (wr_sel_ok) sel5_nxt = HWDATA[`SEL_W-1:0];
        end
        `OFS_LOGIC1: begin
          if (wr_logic_ok) logic1_nxt = HWDATA[`LOGIC_W-1:0];
        end
        `OFS_LOGIC2: begin
          if (wr_logic_ok) logic2_nxt = HWDATA[`LOGIC_W-1:0];
        end
        `OFS_LOGIC3: begin
          if (wr_logic_ok) logic3_nxt = HWDATA[`LOGIC_W-1:0];
        end
        `OFS_LOGIC4: begin
          if (wr_logic_ok) logic4_nxt = HWDATA[`LOGIC_W-1:0];
        end
        `OFS_SPEED_LIM: begin
          speed_lim_nxt = HWDATA[`FREQ_W-1:0];
        end
        `OFS_STATUS: begin
          if (HWDATA[`ST_REJECT_BIT]) reject_nxt = 1'b0;
        end
        default: begin
          reject_nxt = reject_r;
        end
      endcase
      // A refused write sets the flag; the set wins over a clear
      if ((addr_is_sel && !wr_sel_ok) || (addr_is_logic && !wr_logic_ok)) begin
        reject_nxt = 1'b1;
      end
    end
  end

  // Read data from next values so a read right after a write sees it.
  // A read address phase overlaps the data phase of the write before it,
  // and the registers do not hold the new value until that edge has passed.
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (HADDR[7:0])
      `OFS_SEL1:      rdata_nxt[`SEL_W-1:0]   = sel1_nxt;
      `OFS_SEL2:      rdata_nxt[`SEL_W-1:0]   = sel2_nxt;
      `OFS_SEL3:      rdata_nxt[`SEL_W-1:0]   = sel3_nxt;
      `OFS_SEL4:      rdata_nxt[`SEL_W-1:0]   = sel4_nxt;
      `OFS_SEL5:      rdata_nxt[`SEL_W-1:0]   = sel5_nxt;
      `OFS_LOGIC1:    rdata_nxt[`LOGIC_W-1:0] = logic1_nxt;
      `OFS_LOGIC2:    rdata_nxt[`LOGIC_W-1:0] = logic2_nxt;
      `OFS_LOGIC3:    rdata_nxt[`LOGIC_W-1:0] = logic3_nxt;
      `OFS_LOGIC4:    rdata_nxt[`LOGIC_W-1:0] = logic4_nxt;
      `OFS_SPEED_LIM: rdata_nxt[`FREQ_W-1:0]  = speed_lim_nxt;
      `OFS_STATUS: begin
        rdata_nxt[4:0]            = out_now;
        rdata_nxt[`ST_REJECT_BIT] = reject_nxt;
      end
      `OFS_SRC_LO:    rdata_nxt       = src[31:0];
      `OFS_SRC_HI:    rdata_nxt       = src[63:32];
      `OFS_SRC_TOP:   rdata_nxt[0]    = src[64];
      default:        rdata_nxt       = 32'h0000_0000;
    endcase
    if (HADDR[31:8] != 24'h00_0000) begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  // Bus phase tracking and read data; zero wait states, always OKAY
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (HREADY) begin
        wr_pend_r <= addr_ok & HWRITE & (HADDR[31:8] == 24'h00_0000);
        wr_addr_r <= HADDR[7:0];
      end
      if (addr_ok & ~HWRITE) begin
        HRDATA <= rdata_nxt;
      end
    end
  end

  // Configuration registers
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sel1_r                 <= `SEL_RST;
      sel2_r                 <= `SEL_RST;
      sel3_r                 <= `SEL_RST;
      sel4_r                 <= `SEL_RST;
      sel5_r                 <= `SEL_RST;
      CUSTOM_LOGIC_SETTING_1 <= `LOGIC_RST;
      CUSTOM_LOGIC_SETTING_2 <= `LOGIC_RST;
      CUSTOM_LOGIC_SETTING_3 <= `LOGIC_RST;
      CUSTOM_LOGIC_SETTING_4 <= `LOGIC_RST;
      speed_lim_r            <= `SPEED_LIM_RST;
      reject_r               <= 1'b0;
    end else begin
      sel1_r                 <= sel1_nxt;
      sel2_r                 <= sel2_nxt;
      sel3_r                 <= sel3_nxt;
      sel4_r                 <= sel4_nxt;
      sel5_r                 <= sel5_nxt;
      CUSTOM_LOGIC_SETTING_1 <= logic1_nxt;
      CUSTOM_LOGIC_SETTING_2 <= logic2_nxt;
      CUSTOM_LOGIC_SETTING_3 <= logic3_nxt;
      CUSTOM_LOGIC_SETTING_4 <= logic4_nxt;
      speed_lim_r            <= speed_lim_nxt;
      reject_r               <= reject_nxt;
    end
  end

  // Source vector, indexed by selector code; unlisted codes stay zero.
  // The high speed code is taken as the complement of the low speed one,
  // an assumption that is still to be confirmed.
  // Precharge status only means something in active front end mode, so it
  // is masked outside that mode rather than passed through.
  always @* begin
    src = {`NUM_SRC{1'b0}};
    src[`CODE_RUN]        = DRIVE_RUNNING;
    src[`CODE_FAULT]      = FAULT_STOP;
    src[`CODE_BRAKE]      = BRAKE_RELEASE_OK;
    src[`CODE_RUN_REQ]    = RUN_REQUEST;
    src[`CODE_READY]      = DRIVE_READY;
    src[`CODE_STEP0]      = SPEED_STEP_BIT0;
    src[`CODE_STEP0+1]    = SPEED_STEP_BIT1;
    src[`CODE_STEP0+2]    = SPEED_STEP_BIT2;
    src[`CODE_STEP0+3]    = SPEED_STEP_BIT3;
    src[`CODE_DIR]        = DIRECTION_CMD;
    src[`CODE_WARN]       = ANY_FAULT;
    src[`CODE_OT]         = OVERHEAT_WARNING;
    src[`CODE_OL]         = OVERLOAD_WARNING;
    src[`CODE_OS]         = OVERSPEED_WARNING;
    src[`CODE_MOTOR1]     = MOTOR1_SELECTED;
    src[`CODE_MOTOR1+1]   = MOTOR2_SELECTED;
    src[`CODE_MOTOR1+2]   = MOTOR3_SELECTED;
    src[`CODE_MOTOR1+3]   = MOTOR4_SELECTED;
    src[`CODE_LOW_SPD]    = (OUTPUT_FREQ < speed_lim_r);
    src[`CODE_HIGH_SPD]   = (OUTPUT_FREQ >= speed_lim_r);
    src[`CODE_PRECHARGE]  = PRECHARGE_STATUS & ACTIVE_FRONT_END;
    src[`CODE_FIELDBUS1]   = FIELDBUS_FUNC[0];
    src[`CODE_FIELDBUS1+1] = FIELDBUS_FUNC[1];
    src[`CODE_FIELDBUS1+2] = FIELDBUS_FUNC[2];
    src[`CODE_FIELDBUS1+3] = FIELDBUS_FUNC[3];
    src[`CODE_FIELDBUS1+4] = FIELDBUS_FUNC[4];
    src[`CODE_LOCAL1]     = LOCAL_FUNC[0];
    src[`CODE_LOCAL1+1]   = LOCAL_FUNC[1];
    src[`CODE_LOCAL1+2]   = LOCAL_FUNC[2];
    src[`CODE_LOCAL1+3]   = LOCAL_FUNC[3];
    src[`CODE_FREE1]      = FREE_BLOCK_RESULT[0];
    src[`CODE_FREE1+1]    = FREE_BLOCK_RESULT[1];
    src[`CODE_FREE1+2]    = FREE_BLOCK_RESULT[2];
    src[`CODE_FREE1+3]    = FREE_BLOCK_RESULT[3];
  end

  // Selector codes packed for the per-terminal pickers
  assign sel_bus = {sel5_r, sel4_r, sel3_r, sel2_r, sel1_r};

  // One picker per terminal
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_term
      source_pick u_pick (
        .sel  (sel_bus[gi*`SEL_W +: `SEL_W]),
        .src  (src),
        .pick (pick[gi])
      );
    end
  endgenerate

  // Terminal outputs registered; inactive from reset.
  // Registering keeps picker glitches off the pins; a source change or a
  // new code shows on the terminal one clock later.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      SWITCH_OUT_1 <= 1'b0;
      SWITCH_OUT_2 <= 1'b0;
      SWITCH_OUT_3 <= 1'b0;
      SWITCH_OUT_4 <= 1'b0;
      SWITCH_OUT_5 <= 1'b0;
    end else begin
      SWITCH_OUT_1 <= pick[0];
      SWITCH_OUT_2 <= pick[1];
      SWITCH_OUT_3 <= pick[2];
      SWITCH_OUT_4 <= pick[3];
      SWITCH_OUT_5 <= pick[4];
    end
  end

endmodule // status_output_selector

//--- hw/selector_defs.vh
// Constants for the status output selector: register offsets, field
// positions, reset values and source codes. Assumes a 32-bit AHB-Lite bus.
//
// Contract
// - Five output terminals, each picks its source by its own code 0..64, default 0.
// - Code 0 leaves the terminal inactive.
// - Code 1 follows the drive running state.
// - Code 2 is on when the drive stopped on a fault.
// - Code 3 is on when brake release conditions are met.
// - Code 4 is on once a run command is received.
// - Code 5 is on while the drive is ready to run.
// - Codes 6..9 follow speed step command bits 0..3.
// - Code 11 is on when a direction command is received.
// - Code 12 is on while any drive fault is present.
// - Codes 13..15 follow overheat, overload and overspeed faults.
// - Codes 17..20 are on when motor 1..4 is the selected motor.
// - Code 22 is on while output frequency is below the speed limit.
// - Code 32 follows precharge status, only in active front end mode.
// - Codes 49..53 copy fieldbus functions 1..5.
// - Codes 57..60 copy local functions 1..4.
// - Codes 61..64 copy free function block results 1..4.
// - Four free block settings, each 0..500, default 0.
`ifndef SELECTOR_DEFS_VH
`define SELECTOR_DEFS_VH

// Register byte offsets
`define OFS_SEL1        8'h00
`define OFS_SEL2        8'h04
`define OFS_SEL3        8'h08
`define OFS_SEL4        8'h0C
`define OFS_SEL5        8'h10
`define OFS_LOGIC1      8'h14
`define OFS_LOGIC2      8'h18
`define OFS_LOGIC3      8'h1C
`define OFS_LOGIC4      8'h20
`define OFS_SPEED_LIM   8'h24
`define OFS_STATUS      8'h28
`define OFS_SRC_LO      8'h2C
`define OFS_SRC_HI      8'h30
`define OFS_SRC_TOP     8'h34

// Field widths, limits and reset values
`define SEL_W           7
`define LOGIC_W         9
`define FREQ_W          16
`define SEL_MAX         7'h40
`define LOGIC_MAX       9'h1F4
`define SEL_RST         7'h00
`define LOGIC_RST       9'h000
`define SPEED_LIM_RST   16'h0000
`define NUM_SRC         65

// Status register fields
`define ST_REJECT_BIT   8

// Source codes
`define CODE_RUN        1
`define CODE_FAULT      2
`define CODE_BRAKE      3
`define CODE_RUN_REQ    4
`define CODE_READY      5
`define CODE_STEP0      6
`define CODE_DIR        11
`define CODE_WARN       12
`define CODE_OT         13
`define CODE_OL         14
`define CODE_OS         15
`define CODE_MOTOR1     17
`define CODE_LOW_SPD    22
`define CODE_HIGH_SPD   23
`define CODE_PRECHARGE  32
`define CODE_FIELDBUS1  49
`define CODE_LOCAL1     57
`define CODE_FREE1      61

`endif

//--- hw/source_pick.v
// One terminal's source picker: selects one bit of the source vector.
// Assumes the code register never holds a value above the top code.
`include "selector_defs.vh"

module source_pick (
  // Selection
  input  wire [`SEL_W-1:0]   sel,
  // Candidate sources, index equals code
  input  wire [`NUM_SRC-1:0] src,
  // Picked level
  output reg                 pick
);

  // Code 0 and reserved codes map to zero bits of the vector
  always @* begin
    pick = 1'b0;
    if (sel <= `SEL_MAX) begin
      pick = src[sel];
    end
  end

endmodule // source_pick

//--- testbench/selector_chk.sv
// Checker for the status output selector: terminal 1 against a shadow of its code.
// Assumes single word writes on AHB-Lite with one slave on the bus.
`include "selector_defs.vh"
module selector_chk (
  // Clock, reset and bus
  input logic                CLOCK,
  input logic                RST_N,
  input logic                HSEL,
  input logic [31:0]         HADDR,
  input logic [1:0]          HTRANS,
  input logic                HWRITE,
  input logic [31:0]         HWDATA,
  input logic                HREADY,
  // Sources
  input logic                DRIVE_RUNNING,
  input logic                FAULT_STOP,
  input logic                SPEED_STEP_BIT3,
  input logic                MOTOR2_SELECTED,
  input logic                PRECHARGE_STATUS,
  input logic                ACTIVE_FRONT_END,
  input logic [3:0]          FREE_BLOCK_RESULT,
  // Settings and terminals
  input logic [`LOGIC_W-1:0] CUSTOM_LOGIC_SETTING_1,
  input logic                SWITCH_OUT_1,
  input logic                SWITCH_OUT_2,
  input logic                SWITCH_OUT_3,
  input logic                SWITCH_OUT_4,
  input logic                SWITCH_OUT_5
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] sh_r;
  logic       wr_r;
  wire        rsv = sh_r == 7'h0A || sh_r == 7'h10 || sh_r == 7'h15 ||
                    (sh_r >= 7'h18 && sh_r <= 7'h1F) || (sh_r >= 7'h21 && sh_r <= 7'h30) ||
                    (sh_r >= 7'h36 && sh_r <= 7'h38);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Shadow of the terminal 1 code; codes above the top one are refused
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sh_r <= 7'h00;
      wr_r <= 1'b0;
    end else begin
      wr_r <= HSEL & HREADY & HTRANS[1] & HWRITE & (HADDR == 32'h0000_0000);
      if (wr_r && HWDATA <= 32'h0000_0040)
        sh_r <= HWDATA[6:0];
    end
  end
  property p_boot; $rose(RST_N) |-> ({SWITCH_OUT_1, SWITCH_OUT_2, SWITCH_OUT_3,
    SWITCH_OUT_4, SWITCH_OUT_5} == 5'h00) [*2]; endproperty
  a_boot: assert property (p_boot) else $error("terminal on after reset");
  property p_off; sh_r == 7'h00 |=> !SWITCH_OUT_1; endproperty
  a_off: assert property (p_off) else $error("terminal on with code 0");
  property p_run; sh_r == 7'h01 |=> SWITCH_OUT_1 == $past(DRIVE_RUNNING); endproperty
  a_run: assert property (p_run) else $error("run source not followed");
  property p_flt; sh_r == 7'h02 |=> SWITCH_OUT_1 == $past(FAULT_STOP); endproperty
  a_flt: assert property (p_flt) else $error("fault source not followed");
  property p_step; sh_r == 7'h09 |=> SWITCH_OUT_1 == $past(SPEED_STEP_BIT3); endproperty
  a_step: assert property (p_step) else $error("step bit 3 not followed");
  property p_mot; sh_r == 7'h12 |=> SWITCH_OUT_1 == $past(MOTOR2_SELECTED); endproperty
  a_mot: assert property (p_mot) else $error("motor 2 not followed");
  property p_pre; sh_r == 7'h20 |=>
    SWITCH_OUT_1 == $past(PRECHARGE_STATUS & ACTIVE_FRONT_END); endproperty
  a_pre: assert property (p_pre) else $error("precharge not followed");
  property p_free; sh_r >= 7'h3D |=>
    SWITCH_OUT_1 == $past(FREE_BLOCK_RESULT[sh_r - 7'h3D]); endproperty
  a_free: assert property (p_free) else $error("free block not followed");
  property p_rsv; rsv |=> !SWITCH_OUT_1; endproperty
  a_rsv: assert property (p_rsv) else $error("terminal on with reserved code");
  property p_set; CUSTOM_LOGIC_SETTING_1 <= 9'h1F4; endproperty
  a_set: assert property (p_set) else $error("setting above its top");
endmodule // selector_chk

bind status_output_selector selector_chk u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .DRIVE_RUNNING(DRIVE_RUNNING),
  .FAULT_STOP(FAULT_STOP), .SPEED_STEP_BIT3(SPEED_STEP_BIT3),
  .MOTOR2_SELECTED(MOTOR2_SELECTED), .PRECHARGE_STATUS(PRECHARGE_STATUS),
  .ACTIVE_FRONT_END(ACTIVE_FRONT_END), .FREE_BLOCK_RESULT(FREE_BLOCK_RESULT),
  .CUSTOM_LOGIC_SETTING_1(CUSTOM_LOGIC_SETTING_1), .SWITCH_OUT_1(SWITCH_OUT_1),
  .SWITCH_OUT_2(SWITCH_OUT_2), .SWITCH_OUT_3(SWITCH_OUT_3),
  .SWITCH_OUT_4(SWITCH_OUT_4), .SWITCH_OUT_5(SWITCH_OUT_5));

//--- testbench/switch_load.sv
// Model of the switch loads: they see the terminal levels one clock late.
// Assumes the terminals are plain push-pull levels, high is ON.
module switch_load (
  // Clock
  input  logic       clk,
  // Terminal levels, bit 0 is terminal 1
  input  logic [4:0] drive,
  // Levels as the loads see them
  output logic [4:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // Load input stage
  always @(posedge clk) seen <= drive;
endmodule // switch_load

//--- testbench/tb.sv
// Bench for the status output selector: every source code, speed compare,
// refusals and reset values. Assumes the design's AHB-Lite slave timing.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [64:0] sv = '0;
  logic [15:0] freq = 16'h0000;
  logic        afe = 1'b1;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire  [8:0]  cls [4];
  wire  [4:0]  out;
  wire  [4:0]  seen;
  int          error_cnt = 0;
  int          checks = 0;

  status_output_selector u_dut (
    .CLOCK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .DRIVE_RUNNING(sv[1]),
    .FAULT_STOP(sv[2]), .BRAKE_RELEASE_OK(sv[3]), .RUN_REQUEST(sv[4]),
    .DRIVE_READY(sv[5]), .DIRECTION_CMD(sv[11]), .SPEED_STEP_BIT0(sv[6]),
    .SPEED_STEP_BIT1(sv[7]), .SPEED_STEP_BIT2(sv[8]), .SPEED_STEP_BIT3(sv[9]),
    .ANY_FAULT(sv[12]), .OVERHEAT_WARNING(sv[13]), .OVERLOAD_WARNING(sv[14]),
    .OVERSPEED_WARNING(sv[15]), .MOTOR1_SELECTED(sv[17]), .MOTOR2_SELECTED(sv[18]),
    .MOTOR3_SELECTED(sv[19]), .MOTOR4_SELECTED(sv[20]), .OUTPUT_FREQ(freq),
    .PRECHARGE_STATUS(sv[32]), .ACTIVE_FRONT_END(afe), .FIELDBUS_FUNC(sv[53:49]),
    .LOCAL_FUNC(sv[60:57]), .FREE_BLOCK_RESULT(sv[64:61]),
    .CUSTOM_LOGIC_SETTING_1(cls[0]), .CUSTOM_LOGIC_SETTING_2(cls[1]),
    .CUSTOM_LOGIC_SETTING_3(cls[2]), .CUSTOM_LOGIC_SETTING_4(cls[3]),
    .SWITCH_OUT_1(out[0]), .SWITCH_OUT_2(out[1]), .SWITCH_OUT_3(out[2]),
    .SWITCH_OUT_4(out[3]), .SWITCH_OUT_5(out[4]));

  switch_load u_load (.clk(clk), .drive(out), .seen(seen));

  // Clock
  always #2 clk = ~clk;

  // One single transfer; each phase is held until hready is seen high,
  // only the watchdog ends a wait that never closes
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do begin @(posedge clk); end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); end while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Reset values of registers up to status, the bus response and terminals
  task automatic t_reset();
    logic [31:0] q;
    for (int i = 0; i < 11; i++) begin
      ahb(1'b0, 8'(4 * i), 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      chk(32'(hresp), 32'h0000_0000);
    end
    chk(32'(seen), 32'h0000_0000);
  endtask

  // Every code on a rotating terminal, lone source high and lone source low
  task automatic t_codes();
    int  t;
    logic m;
    for (int c = 0; c <= 64; c++) begin
      t = c % 5;
      m = (c >= 1 && c <= 9) || (c >= 11 && c <= 15) || (c >= 17 && c <= 20) ||
          c == 32 || (c >= 49 && c <= 53) || c >= 57;
      wr(8'(4 * t), 32'(c));
      wr(8'h00, 32'(c));
      sv <= 65'h1 << c;
      repeat (3) @(posedge clk);
      chk(32'(seen[t]), 32'(m | (c == 23)));
      chk(32'(seen[0]), 32'(m | (c == 23)));
      sv <= ~(65'h1 << c);
      repeat (3) @(posedge clk);
      chk(32'(seen[t]), 32'(c == 23));
      chk(32'(seen[0]), 32'(c == 23));
    end
    wr(8'h00, 32'h0000_0020);
    afe <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(seen[0]), 32'h0000_0000);
    afe <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(seen[0]), 32'h0000_0001);
  endtask

  // Speed compare at the limit boundary
  task automatic t_speed();
    wr(8'h24, 32'h0000_03E8);
    wr(8'h00, 32'h0000_0016);
    wr(8'h04, 32'h0000_0017);
    freq <= 16'h03E7;
    repeat (3) @(posedge clk);
    chk(32'(seen[1:0]), 32'h0000_0001);
    freq <= 16'h03E8;
    repeat (3) @(posedge clk);
    chk(32'(seen[1:0]), 32'h0000_0002);
  endtask

  // Refused codes and settings, top settings, unmapped address
  task automatic t_regs();
    logic [31:0] q;
    wr(8'h00, 32'h0000_0005);
    wr(8'h00, 32'h0000_0041);
    ahb(1'b0, 8'h00, 32'h0000_0000, q);
    chk(q, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      wr(8'h14 + 8'(4 * i), 32'(500 - i));
      wr(8'h14 + 8'(4 * i), 32'h0000_01F5);
      ahb(1'b0, 8'h14 + 8'(4 * i), 32'h0000_0000, q);
      chk(q, 32'(500 - i));
      chk(32'(cls[i]), 32'(500 - i));
    end
    ahb(1'b0, 8'h3C, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    // Status: terminals 1..4 on, 5 off, refusal flag set, then cleared
    ahb(1'b0, 8'h28, 32'h0000_0000, q);
    chk(q, 32'h0000_010F);
    wr(8'h28, 32'h0000_0100);
    ahb(1'b0, 8'h28, 32'h0000_0000, q);
    chk(q, 32'h0000_000F);
  endtask

  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_codes();
    t_speed();
    t_regs();
    final_report();
  end

  // Watchdog, far beyond the several hundred cycles the tests take
  initial begin
    #100us;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule // tb
